// ===== src/ppa_pkg.sv
package ppa_pkg;

  // ****************************************************************
  // Register map (byte addresses on the AHB-Lite bus)
  // ****************************************************************
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFS_TIMING  = 8'h00;
  localparam logic [7:0]  OFS_ADDR    = 8'h04;
  localparam logic [7:0]  OFS_PINEN   = 8'h08;
  localparam logic [7:0]  OFS_CTRL    = 8'h0C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned TM_BUSY_BIT   = 15;
  localparam int unsigned TM_STEP_LSB   = 11;
  localparam int unsigned TM_SETUP_LSB  = 6;
  localparam int unsigned TM_STROBE_LSB = 2;
  localparam int unsigned TM_HOLD_LSB   = 0;
  localparam int unsigned AD_MSB_BIT    = 15;
  localparam int unsigned AD_CS_BIT     = 14;
  localparam int unsigned AD_STEP_W     = 11;
  localparam int unsigned PE_CS_BIT     = 14;
  localparam int unsigned PE_WIDE_LO    = 2;
  localparam int unsigned PE_WIDE_HI    = 10;
  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned CTRL_DIR_BIT  = 1;

  // ****************************************************************
  // Write masks and reset values
  // ****************************************************************
  localparam logic [15:0] TM_WR_MASK    = 16'h7FFF;
  localparam logic [15:0] PE_WR_MASK    = 16'h47FF;
  localparam logic [15:0] TM_RESET      = 16'h0000;
  localparam logic [15:0] AD_RESET      = 16'h0000;
  localparam logic [15:0] PE_RESET      = 16'h0000;

  // ****************************************************************
  // Step modes and timing counts (instruction cycles)
  // ****************************************************************
  localparam logic [1:0]  STEP_INC      = 2'b01;
  localparam logic [3:0]  STROBE_NONE   = 4'h0;
  localparam logic [2:0]  PHASE_MIN     = 3'h1;

endpackage

// ===== src/ppa_seq_if.sv
`timescale 1ns/100ps
interface ppa_seq_if;
  logic       start;
  logic [2:0] setup_len;
  logic [4:0] strobe_len;
  logic [2:0] hold_len;
  logic       busy;
  logic       setup_ph;
  logic       strobe_ph;
  logic       hold_ph;
  logic       done;

  modport cfg (output start, output setup_len, output strobe_len, output hold_len,
               input busy, input setup_ph, input strobe_ph, input hold_ph, input done);
  modport seq (input start, input setup_len, input strobe_len, input hold_len,
               output busy, output setup_ph, output strobe_ph, output hold_ph, output done);
endinterface

// ===== src/ppa_cycle_seq.sv
`timescale 1ns/100ps
module ppa_cycle_seq (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   rst,
  // Sequencer link
  ppa_seq_if.seq      bus
);

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SETUP  = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD   = 4'b1000
  } ppa_state_t;

  ppa_state_t state_q;
  ppa_state_t state_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       done_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (bus.start) begin
          state_d = ST_SETUP;
          cnt_d   = 5'({2'b00, bus.setup_len} - 5'd1);
        end
      end
      ST_SETUP: begin
        if (cnt_q == 5'd0) begin
          state_d = ST_STROBE;
          cnt_d   = 5'(bus.strobe_len - 5'd1);
        end else begin
          cnt_d = 5'(cnt_q - 5'd1);
        end
      end
      ST_STROBE: begin
        if (cnt_q == 5'd0) begin
          state_d = ST_HOLD;
          cnt_d   = 5'({2'b00, bus.hold_len} - 5'd1);
        end else begin
          cnt_d = 5'(cnt_q - 5'd1);
        end
      end
      ST_HOLD: begin
        if (cnt_q == 5'd0) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end else begin
          cnt_d = 5'(cnt_q - 5'd1);
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 5'd0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'd0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign bus.busy      = (state_q != ST_IDLE);
  assign bus.setup_ph  = (state_q == ST_SETUP);
  assign bus.strobe_ph = (state_q == ST_STROBE);
  assign bus.hold_ph   = (state_q == ST_HOLD);
  assign bus.done      = done_d;

  a_phase_order: assert property (@(posedge mclk) disable iff (rst)
    $fell(bus.setup_ph) |-> bus.strobe_ph && !bus.hold_ph)
    else $error("Strobe did not follow setup");

  a_done_idle: assert property (@(posedge mclk) disable iff (rst)
    bus.done |-> bus.hold_ph ##1 !bus.busy)
    else $error("Cycle end did not return to idle");

endmodule

// ===== src/ppa_port_cfg.sv
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - Strobe wait code adds that many extra cycles to the strobe
// - Zero strobe wait makes setup and hold codes count as zero
// - Address register bit 15 is the top destination address bit
// - Address register bit 14 drives chip select one, 1 is active
// - Address register bits 13..0 give the low destination address
// - Pin enable 14 hands pin 14 to the port, else general I/O
// - Pin enables 10..2 hand their address pins to the port
// - Pin enables 1..0 hand pins 1..0 to the port for address/latch
// - Small package has no pins 10..2; their enables do nothing
// - Step mode 01 adds one to address bits 10..0 after each cycle, except when an address write lands in its last clock
module ppa_port_cfg #(
  parameter bit          PIN28 = 1'b0,
  parameter int unsigned NPINS = 15
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // General I/O side of the pads
  input  wire logic [NPINS-1:0]  gpio_out,
  input  wire logic [NPINS-1:0]  gpio_oe_n,
  // Pads
  output logic [NPINS-1:0]       parallel_addr_pins,
  output logic [NPINS-1:0]       parallel_addr_oe_n,
  // Cycle strobes and busy flag
  output logic                   rd_strobe,
  output logic                   wr_strobe,
  output logic                   port_busy
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [2:0] edge_len(input logic [1:0] code, input logic [3:0] strobe);
    logic [2:0] len;
    len = 3'({1'b0, code} + 3'd1);
    if (strobe == ppa_pkg::STROBE_NONE) begin
      len = ppa_pkg::PHASE_MIN;
    end
    return len;
  endfunction

  function automatic logic pin_owned(input int unsigned idx, input logic [15:0] pe);
    logic own;
    own = 1'b0;
    if (idx == ppa_pkg::PE_CS_BIT) begin
      own = pe[idx];
    end else if (idx >= ppa_pkg::PE_WIDE_LO && idx <= ppa_pkg::PE_WIDE_HI) begin
      own = pe[idx] && !PIN28;
    end else if (idx < ppa_pkg::PE_WIDE_LO) begin
      own = pe[idx];
    end
    return own;
  endfunction

  function automatic logic [15:0] read_word(input logic [7:0] ofs, input logic [15:0] tm,
                                            input logic [15:0] ad, input logic [15:0] pe,
                                            input logic busy, input logic dir);
    logic [15:0] w;
    w = 16'h0000;
    unique case (ofs)
      ppa_pkg::OFS_TIMING: begin
        w = tm;
        w[ppa_pkg::TM_BUSY_BIT] = busy;
      end
      ppa_pkg::OFS_ADDR:  w = ad;
      ppa_pkg::OFS_PINEN: w = pe & ppa_pkg::PE_WR_MASK;
      ppa_pkg::OFS_CTRL:  w = {14'h0000, dir, busy};
      default:            w = 16'h0000;
    endcase
    return w;
  endfunction

  // ****************************************************************
  // Registers and fields
  // ****************************************************************
  logic [15:0] tm_q;
  logic [15:0] tm_d;
  logic [15:0] ad_q;
  logic [15:0] ad_d;
  logic [15:0] pe_q;
  logic [15:0] pe_d;
  logic        go_q;
  logic        go_d;
  logic        dir_q;
  logic        dir_d;
  logic        busy_any;
  logic [1:0]  data_setup_wait;
  logic [3:0]  strobe_wait;
  logic [1:0]  data_hold_wait;
  logic [1:0]  addr_step_mode;

  ppa_seq_if sif ();

  assign data_setup_wait = tm_q[ppa_pkg::TM_SETUP_LSB +: 2];
  assign strobe_wait     = tm_q[ppa_pkg::TM_STROBE_LSB +: 4];
  assign data_hold_wait  = tm_q[ppa_pkg::TM_HOLD_LSB +: 2];
  assign addr_step_mode  = tm_q[ppa_pkg::TM_STEP_LSB +: 2];
  assign busy_any        = sif.busy | go_q;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic        dph_wr_q;
  logic        dph_wr_d;
  logic [7:0]  dph_ofs_q;
  logic [7:0]  dph_ofs_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic        aph_valid;

  assign aph_valid = hsel && hready && htrans[1];

  always_comb begin
    dph_wr_d  = aph_valid && hwrite;
    dph_ofs_d = aph_valid ? haddr[ppa_pkg::ADDR_W-1:0] : dph_ofs_q;
    hrdata_d  = hrdata_q;
    if (aph_valid && !hwrite) begin
      hrdata_d = {16'h0000, read_word(haddr[ppa_pkg::ADDR_W-1:0], tm_d, ad_d, pe_d,
                                      sif.busy || go_d, dir_d)};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dph_wr_q  <= 1'b0;
      dph_ofs_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      dph_wr_q  <= dph_wr_d;
      dph_ofs_q <= dph_ofs_d;
      hrdata_q  <= hrdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_comb begin
    tm_d  = tm_q;
    ad_d  = ad_q;
    pe_d  = pe_q;
    go_d  = 1'b0;
    dir_d = dir_q;
    if (sif.done && addr_step_mode == ppa_pkg::STEP_INC) begin
      ad_d[ppa_pkg::AD_STEP_W-1:0] = 11'(ad_q[ppa_pkg::AD_STEP_W-1:0] + 11'd1);
    end
    if (dph_wr_q) begin
      unique case (dph_ofs_q)
        ppa_pkg::OFS_TIMING: begin
          if (!busy_any) begin
            tm_d = hwdata[15:0] & ppa_pkg::TM_WR_MASK;
          end
        end
        ppa_pkg::OFS_ADDR: begin
          ad_d = hwdata[15:0];
        end
        ppa_pkg::OFS_PINEN: begin
          pe_d = hwdata[15:0] & ppa_pkg::PE_WR_MASK;
        end
        ppa_pkg::OFS_CTRL: begin
          if (!busy_any && hwdata[ppa_pkg::CTRL_GO_BIT]) begin
            go_d  = 1'b1;
            dir_d = hwdata[ppa_pkg::CTRL_DIR_BIT];
          end
        end
        default: begin
          tm_d = tm_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tm_q  <= ppa_pkg::TM_RESET;
      ad_q  <= ppa_pkg::AD_RESET;
      pe_q  <= ppa_pkg::PE_RESET;
      go_q  <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      tm_q  <= tm_d;
      ad_q  <= ad_d;
      pe_q  <= pe_d;
      go_q  <= go_d;
      dir_q <= dir_d;
    end
  end

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  assign sif.start      = go_q;
  assign sif.setup_len  = edge_len(data_setup_wait, strobe_wait);
  assign sif.strobe_len = 5'({1'b0, strobe_wait} + 5'd1);
  assign sif.hold_len   = edge_len(data_hold_wait, strobe_wait);

  ppa_cycle_seq u_seq (
    .mclk (mclk),
    .rst  (rst),
    .bus  (sif)
  );

  assign rd_strobe = sif.strobe_ph && !dir_q;
  assign wr_strobe = sif.strobe_ph && dir_q;
  assign port_busy = sif.busy;

  // ****************************************************************
  // Pad ownership
  // ****************************************************************
  always_comb begin
    for (int unsigned i = 0; i < NPINS; i++) begin
      if (pin_owned(i, pe_q)) begin
        parallel_addr_pins[i] = ad_q[i];
        parallel_addr_oe_n[i] = 1'b0;
      end else begin
        parallel_addr_pins[i] = gpio_out[i];
        parallel_addr_oe_n[i] = gpio_oe_n[i];
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [2:0] ph_q;
  logic [2:0] ph_now;
  logic [4:0] run_q;
  logic [4:0] run_d;

  assign ph_now = {sif.hold_ph, sif.strobe_ph, sif.setup_ph};

  always_comb begin
    run_d = (ph_now == ph_q) ? 5'(run_q + 5'd1) : 5'd1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ph_q  <= 3'b000;
      run_q <= 5'd0;
    end else begin
      ph_q  <= ph_now;
      run_q <= run_d;
    end
  end

  a_setup_time: assert property (@(posedge mclk) disable iff (rst)
    $fell(sif.setup_ph) |-> $past(run_d) == {2'b00, $past(sif.setup_len)})
    else $error("Setup phase length wrong");

  a_strobe_time: assert property (@(posedge mclk) disable iff (rst)
    $fell(sif.strobe_ph) |-> $past(run_d) == 5'({1'b0, $past(strobe_wait)} + 5'd1))
    else $error("Strobe phase length wrong");

  a_zero_wait: assert property (@(posedge mclk) disable iff (rst)
    $rose(sif.setup_ph) && strobe_wait == ppa_pkg::STROBE_NONE |-> ##1 sif.strobe_ph ##1 sif.hold_ph ##1 !sif.busy)
    else $error("Zero strobe wait did not give minimal cycle");

  a_msb_read: assert property (@(posedge mclk) disable iff (rst)
    aph_valid && !hwrite && haddr[7:0] == ppa_pkg::OFS_ADDR && !dph_wr_q && !sif.done
      |=> hrdata[ppa_pkg::AD_MSB_BIT] == ad_q[ppa_pkg::AD_MSB_BIT])
    else $error("Address top bit not read back");

  a_cs_pin: assert property (@(posedge mclk) disable iff (rst)
    $rose(pe_q[ppa_pkg::PE_CS_BIT]) |-> parallel_addr_pins[ppa_pkg::PE_CS_BIT] == ad_q[ppa_pkg::AD_CS_BIT]
      && !parallel_addr_oe_n[ppa_pkg::PE_CS_BIT])
    else $error("Chip select pin not taken by port");

  a_cs_gpio: assert property (@(posedge mclk) disable iff (rst)
    !pe_q[ppa_pkg::PE_CS_BIT] |-> parallel_addr_pins[ppa_pkg::PE_CS_BIT] == gpio_out[ppa_pkg::PE_CS_BIT])
    else $error("Chip select pin not left to general I/O");

  a_latch_pins: assert property (@(posedge mclk) disable iff (rst)
    pe_q[1:0] == 2'b11 |-> parallel_addr_pins[1:0] == ad_q[1:0] && parallel_addr_oe_n[1:0] == 2'b00)
    else $error("Low address pins not taken by port");

  a_small_pkg: assert property (@(posedge mclk) disable iff (rst)
    PIN28 || pe_q[2] == 1'b0 |-> parallel_addr_pins[2] == gpio_out[2] && parallel_addr_oe_n[2] == gpio_oe_n[2])
    else $error("Absent address pin driven by port");

  a_addr_step: assert property (@(posedge mclk) disable iff (rst)
    sif.done && addr_step_mode == ppa_pkg::STEP_INC && !(dph_wr_q && dph_ofs_q == ppa_pkg::OFS_ADDR)
      |=> ad_q[10:0] == 11'($past(ad_q[10:0]) + 11'd1) && ad_q[15:11] == $past(ad_q[15:11]))
    else $error("Address step wrong");

  a_unimpl_zero: assert property (@(posedge mclk) disable iff (rst)
    aph_valid && !hwrite && haddr[7:0] == ppa_pkg::OFS_PINEN |=> hrdata[15] == 1'b0 && hrdata[13:11] == 3'b000)
    else $error("Unimplemented enable bits not zero");

endmodule

// ===== bench/ppa_periph_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Peripheral on the address pads, records each strobe
// ****************************************************************
module ppa_periph_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Pads and strobes
  input  wire logic [14:0] pins,
  input  wire logic [14:0] pins_oe_n,
  input  wire logic        rd_strobe,
  input  wire logic        wr_strobe,
  // Observations
  output logic      [4:0]  strobe_len,
  output logic      [14:0] seen_addr,
  output logic             seen_write
);
  logic strobe_q;

  // Undriven pads are pulled low
  always @(posedge mclk) begin
    if (rst) begin
      strobe_len <= 5'h00;
      seen_addr  <= 15'h0000;
      seen_write <= 1'b0;
    end else if (rd_strobe || wr_strobe) begin
      strobe_len <= strobe_q ? strobe_len + 5'h01 : 5'h01;
      seen_addr  <= pins & ~pins_oe_n;
      seen_write <= wr_strobe;
    end
    strobe_q <= rd_strobe || wr_strobe;
  end
endmodule

// ===== bench/ppa_port_cfg_bench.sv
`timescale 1ns/100ps
module ppa_port_cfg_bench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        mclk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [14:0] gpio_out;
  logic [14:0] gpio_oe_n;
  logic [14:0] pads;
  logic [14:0] pads_oe_n;
  logic [14:0] small_oe_n;
  logic        rd_strobe;
  logic        wr_strobe;
  logic        port_busy;
  logic [4:0]  strobe_len;
  logic [14:0] seen_addr;
  logic        seen_write;
  int          num_errors;
  int          checks_done;

  assign hready = hreadyout;

  // ****************************************************************
  // Design, small package copy and peripheral
  // ****************************************************************
  ppa_port_cfg #(.PIN28(1'b0), .NPINS(15)) i_ppa_port_cfg (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .parallel_addr_pins(pads),
    .parallel_addr_oe_n(pads_oe_n), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .port_busy(port_busy));

  ppa_port_cfg #(.PIN28(1'b1), .NPINS(15)) i_ppa_port_cfg_small (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(), .hrdata(), .hresp(),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .parallel_addr_pins(),
    .parallel_addr_oe_n(small_oe_n), .rd_strobe(), .wr_strobe(), .port_busy());

  ppa_periph_model i_ppa_periph_model (
    .mclk(mclk), .rst(rst), .pins(pads), .pins_oe_n(pads_oe_n), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .strobe_len(strobe_len), .seen_addr(seen_addr), .seen_write(seen_write));

  // ****************************************************************
  // Bus and checking tasks
  // ****************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    logic [31:0] rd;
    bus(1'b0, ppa_pkg::OFS_ADDR, 16'h0000, rd);
    check(rd, 32'h0000_0000, "address after reset");
    bus(1'b0, ppa_pkg::OFS_PINEN, 16'h0000, rd);
    check(rd, 32'h0000_0000, "pin enable after reset");
    bus(1'b0, 8'h10, 16'h0000, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    check({17'h0_0000, pads_oe_n}, {17'h0_0000, gpio_oe_n}, "pads idle");
    check({31'h0000_0000, hresp}, 32'h0000_0000, "bus response");
  endtask

  task automatic test_regs();
    logic [31:0] rd;
    bus(1'b1, ppa_pkg::OFS_PINEN, 16'hFFFF, rd);
    bus(1'b0, ppa_pkg::OFS_PINEN, 16'h0000, rd);
    check(rd, 32'h0000_47FF, "pin enable mask");
    bus(1'b1, ppa_pkg::OFS_ADDR, 16'hA5C3, rd);
    bus(1'b0, ppa_pkg::OFS_ADDR, 16'h0000, rd);
    check(rd, 32'h0000_A5C3, "address readback");
    bus(1'b1, ppa_pkg::OFS_TIMING, 16'hFFFF, rd);
    bus(1'b0, ppa_pkg::OFS_TIMING, 16'h0000, rd);
    check(rd, 32'h0000_7FFF, "timing readback");
  endtask

  task automatic test_pads(input logic [15:0] a, input logic [15:0] pe);
    logic [31:0] rd;
    logic [14:0] own;
    logic [14:0] own28;
    bus(1'b1, ppa_pkg::OFS_ADDR, a, rd);
    bus(1'b1, ppa_pkg::OFS_PINEN, pe, rd);
    @(posedge mclk);
    own   = pe[14:0] & 15'h47FF;
    own28 = own & 15'h4003;
    check({17'h0_0000, pads_oe_n}, {17'h0_0000, gpio_oe_n & ~own}, "pad enables");
    check({17'h0_0000, pads}, {17'h0_0000, (a[14:0] & own) | (gpio_out & ~own)}, "pad levels");
    check({17'h0_0000, small_oe_n}, {17'h0_0000, gpio_oe_n & ~own28}, "small pads");
  endtask

  task automatic test_cycle(input logic [1:0] mode, input logic [1:0] s, input logic [3:0] m,
                            input logic [1:0] h, input logic dir, input logic [15:0] a);
    logic [31:0] rd;
    int          n;
    int          len;
    len = (m == 4'h0) ? 3 : (s + 1) + (m + 1) + (h + 1);
    bus(1'b1, ppa_pkg::OFS_TIMING, {3'h0, mode, 3'h0, s, m, h}, rd);
    bus(1'b1, ppa_pkg::OFS_ADDR, a, rd);
    bus(1'b1, ppa_pkg::OFS_PINEN, 16'h47FF, rd);
    bus(1'b1, ppa_pkg::OFS_CTRL, {14'h0000, dir, 1'b1}, rd);
    n = 0;
    while (port_busy !== 1'b1 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (port_busy === 1'b1 && n < 64) begin
      @(posedge mclk);
      n++;
    end
    check(32'(n), 32'(len), "busy cycles");
    check({27'h000_0000, strobe_len}, {27'h000_0000, m + 5'h01}, "strobe cycles");
    check({31'h0000_0000, seen_write}, {31'h0000_0000, dir}, "strobe direction");
    // Pads 11..13 stay with general I/O and show its level where it drives
    check({17'h0_0000, seen_addr}, {17'h0_0000, (a[14:0] & 15'h47FF) | (gpio_out & ~gpio_oe_n & 15'h3800)},
          "address on pads");
    bus(1'b0, ppa_pkg::OFS_ADDR, 16'h0000, rd);
    check(rd, {16'h0000, (mode == ppa_pkg::STEP_INC) ? {a[15:11], a[10:0] + 11'h001} : a}, "address step");
  endtask

  // ****************************************************************
  // Clock, main sequence and watchdog
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    rst         = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h0000_0000;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'b010;
    hwdata      = 32'h0000_0000;
    gpio_out    = 15'h3C3C;
    gpio_oe_n   = 15'h5A5A;
    num_errors  = 0;
    checks_done = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    test_reset();
    test_regs();
    test_pads(16'hC00A, 16'hFFFF);
    test_pads(16'h3FF5, 16'h4003);
    test_pads(16'h7FFF, 16'h0000);
    test_cycle(2'b01, 2'b00, 4'h0, 2'b00, 1'b0, 16'h0010);
    test_cycle(2'b01, 2'b11, 4'h0, 2'b11, 1'b1, 16'h87FF);
    test_cycle(2'b00, 2'b01, 4'hF, 2'b10, 1'b0, 16'h4123);
    test_cycle(2'b01, 2'b00, 4'h1, 2'b11, 1'b1, 16'hFFFE);
    results();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    results();
  end
endmodule
